/* File: design/dosar_pkg.sv */
package dosar_pkg;

  // Clock and conversion timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 660;   // Longest conversion time
  // Longest time rounds down, never below one cycle
  localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int CONV_CNT_W = 8;

  // Word widths
  localparam int CODE_W = 32;
  localparam int DIFF_W = 24;
  localparam int CM_W = 7;
  localparam int ACC_W = 48;

  // Field positions of the raw core result used by the composite code
  localparam int DIFF_LSB = 8;

  // Configuration word
  localparam int CFG_BITS = 8;
  localparam int CFG_CNT_W = 3;

  // Synchroniser lane positions
  localparam int LANE_TRIG = 0;
  localparam int LANE_FILTERED_SHIFT_CLOCK = 1;
  localparam int LANE_DIRECT_SHIFT_CLOCK = 2;
  localparam int LANE_ALIGN = 3;
  localparam int LANE_SDI = 4;
  localparam int LANE_PRE = 5;
  localparam int LANE_RDA_N = 6;
  localparam int LANE_RDB_N = 7;
  localparam int LANES = 8;

  // Filter kinds
  typedef enum logic [1:0] {
    FILT_AVERAGE,
    FILT_DECIMATE_ONLY,
    FILT_RSVD2,
    FILT_RSVD3
  } dosar_filt_type;

  // Configuration word layout, sent MSB first
  typedef struct packed {
    logic [1:0] gain_comp;
    dosar_filt_type filt;
    logic [3:0] dsr_log2;
  } dosar_cfg_type;

  // Composite code: overrange on top, common mode at the bottom
  typedef struct packed {
    logic overrange;
    logic [DIFF_W-1:0] diff;
    logic [CM_W-1:0] cm;
  } dosar_composite_type;

  // Values after reset and the two presets
  localparam dosar_cfg_type CFG_RESET = '{2'h0, FILT_AVERAGE, 4'h2};
  localparam dosar_cfg_type CFG_PRESET_LO = '{2'h0, FILT_AVERAGE, 4'h2};
  localparam dosar_cfg_type CFG_PRESET_HI = '{2'h0, FILT_AVERAGE, 4'h8};
  localparam logic [DIFF_W+CM_W:0] COMPOSITE_RESET = 32'h0000_0000;
  localparam logic [CODE_W-1:0] FILTERED_RESET = 32'h0000_0000;

endpackage : dosar_pkg

/* File: design/dosar_shift_out.sv */
`timescale 1ns/10ps
module dosar_shift_out #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Parallel load
  input wire logic load,
  input wire logic [WIDTH-1:0] load_word,
  // Advance one bit
  input wire logic shift,
  // Current bit, straight from a flop
  output logic sout
);

  logic [WIDTH-1:0] word_q;

  // Load wins over shift so a new word is never skewed by one bit
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      word_q <= '0;
    end else if (load) begin
      word_q <= load_word;
    end else if (shift) begin
      word_q <= {word_q[WIDTH-2:0], 1'b0};
    end
  end

  assign sout = word_q[WIDTH-1];

endmodule : dosar_shift_out

/* File: design/dosar_sync.sv */
`timescale 1ns/10ps
module dosar_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Raw pins
  input wire logic [WIDTH-1:0] pin_in,
  // Synchronised levels and rising-edge pulses
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] prev_q;

  // Two flops; the first is read by the second only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_q <= '0;
      level_q <= '0;
    end else begin
      meta_q <= pin_in;
      level_q <= meta_q;
    end
  end

  // Edge finder looks at the settled copy only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= level_q;
    end
  end

  assign level_out = level_q;
  assign rise_out = level_q & ~prev_q;

endmodule : dosar_sync

/* File: design/dosar_top.sv */
// Overview of operation
// R1: Filtered output driven only while its enable low
// R2: Direct output driven only while its enable low
// R3: Preset pin picks preset, else serial word
// R4: Trigger rising edge starts a conversion
// R5: Align pulse restarts the decimation phase
// R6: Ready falls when filtered word loaded
// R7: Config bits taken on filtered clock rise
// R8: Filtered word shifts out MSB first
// R9: Composite code shifts out MSB first
// R10: Busy high from start until conversion ends
// R11: Overrange flag refreshed on every conversion
// R12: Composite is flag, 24 diff, 7 common
// R13: Composite belongs to the same conversion
// R14: Filtered word is averaged then decimated
// R15: Full result handed to filter at end
// R16: Config word sets filter and gain modes
// R17: Host keeps shift clocks quiet after trigger
// R18: Flag on top, common mode at bottom
// R19: Direct shifter loads as busy falls
`timescale 1ns/10ps
module dosar_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Conversion trigger and filter alignment pins
  input wire logic conversion_trigger,
  input wire logic filter_phase_align,
  // Configuration pins
  input wire logic preset_select,
  input wire logic config_serial_in,
  // Shift clocks from the host
  input wire logic filtered_shift_clock,
  input wire logic direct_shift_clock,
  // Output enables from the host
  input wire logic filtered_read_enable_n,
  input wire logic direct_read_enable_n,
  // Converter core result, valid at the end of conversion
  input wire logic [dosar_pkg::CODE_W-1:0] core_result,
  input wire logic [dosar_pkg::CM_W-1:0] core_common_mode,
  input wire logic core_overrange,
  // Status
  output logic busy,
  output logic filtered_ready_n,
  // Filtered serial port
  output logic filtered_serial_out,
  output logic filtered_serial_oe_n,
  // Direct serial port
  output logic direct_serial_out,
  output logic direct_serial_oe_n,
  // Active configuration
  output logic [1:0] gain_compensation_modes,
  output logic [1:0] filter_mode,
  output logic [3:0] decimation_log2
);

  typedef enum logic {
    ST_ACQUIRE,
    ST_CONVERT
  } dosar_state_type;

  localparam logic [dosar_pkg::CONV_CNT_W-1:0] CONV_LAST =
    dosar_pkg::CONV_CNT_W'(dosar_pkg::CONV_CYCLES - 1);
  localparam logic [dosar_pkg::CFG_CNT_W-1:0] CFG_LAST =
    dosar_pkg::CFG_CNT_W'(dosar_pkg::CFG_BITS - 1);

  // Pin synchronisers
  logic [dosar_pkg::LANES-1:0] pins;
  logic [dosar_pkg::LANES-1:0] lvl;
  logic [dosar_pkg::LANES-1:0] rise;

  assign pins[dosar_pkg::LANE_TRIG] = conversion_trigger;
  assign pins[dosar_pkg::LANE_FILTERED_SHIFT_CLOCK] = filtered_shift_clock;
  assign pins[dosar_pkg::LANE_DIRECT_SHIFT_CLOCK] = direct_shift_clock;
  assign pins[dosar_pkg::LANE_ALIGN] = filter_phase_align;
  assign pins[dosar_pkg::LANE_SDI] = config_serial_in;
  assign pins[dosar_pkg::LANE_PRE] = preset_select;
  // Enables enter inverted, so a cleared synchroniser means released;
  // a plain copy would drive both pins for two cycles after reset
  assign pins[dosar_pkg::LANE_RDA_N] = ~filtered_read_enable_n;
  assign pins[dosar_pkg::LANE_RDB_N] = ~direct_read_enable_n;

  dosar_sync #(
    .WIDTH(dosar_pkg::LANES)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .pin_in(pins),
    .level_out(lvl),
    .rise_out(rise)
  );

  // Rising edges and settled levels of the pins used below
  logic trig_rise;
  logic filtered_shift_clock_rise;
  logic direct_shift_clock_rise;
  logic align_rise;
  logic sdi_lvl;
  logic pre_lvl;

  assign trig_rise = rise[dosar_pkg::LANE_TRIG];
  assign filtered_shift_clock_rise = rise[dosar_pkg::LANE_FILTERED_SHIFT_CLOCK];
  assign direct_shift_clock_rise = rise[dosar_pkg::LANE_DIRECT_SHIFT_CLOCK];
  assign align_rise = rise[dosar_pkg::LANE_ALIGN];
  assign sdi_lvl = lvl[dosar_pkg::LANE_SDI];
  assign pre_lvl = lvl[dosar_pkg::LANE_PRE];

  // Conversion sequencer
  dosar_state_type state_q;
  logic [dosar_pkg::CONV_CNT_W-1:0] conv_cnt_q;
  logic busy_q;
  logic conv_done;
  logic conv_start;

  // Start and end of a conversion; both are read by several processes
  assign conv_start = (state_q == ST_ACQUIRE) && trig_rise;
  assign conv_done = (state_q == ST_CONVERT) && (conv_cnt_q == '0);

  // A trigger edge during conversion is ignored; the host owns the rate
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_ACQUIRE;
      conv_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_ACQUIRE: begin
          if (trig_rise) begin
            state_q <= ST_CONVERT;   // [R4]
            conv_cnt_q <= CONV_LAST;
          end
        end
        ST_CONVERT: begin
          if (conv_cnt_q == '0) begin
            state_q <= ST_ACQUIRE;
          end else begin
            conv_cnt_q <= conv_cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= ST_ACQUIRE;
          conv_cnt_q <= '0;
        end
      endcase
    end
  end

  // Busy is set on the edge at which the sequencer leaves acquisition
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else if (conv_start) begin
      busy_q <= 1'b1;   // [R10]
    end else if (conv_done) begin
      busy_q <= 1'b0;   // [R10]
    end
  end

  // Composite code, built from the conversion that just ended
  dosar_pkg::dosar_composite_type composite;

  always_comb begin
    composite.overrange = core_overrange;   // [R11] [R18]
    composite.diff = core_result[dosar_pkg::DIFF_LSB +: dosar_pkg::DIFF_W];
    composite.cm = core_common_mode;   // [R12]
  end

  // Loaded as busy falls, so the first bit shows with no latency
  dosar_shift_out #(
    .WIDTH(dosar_pkg::CODE_W)
  ) u_direct (
    .mclk(mclk),
    .resetn(resetn),
    .load(conv_done),   // [R13] [R19]
    .load_word(composite),
    .shift(direct_shift_clock_rise),   // [R9]
    .sout(direct_serial_out)
  );

  // Configuration intake
  dosar_pkg::dosar_cfg_type cfg_q;
  logic [dosar_pkg::CFG_BITS-2:0] cfg_shift_q;
  logic [dosar_pkg::CFG_CNT_W-1:0] cfg_cnt_q;

  // Word framing restarts with each conversion so a stray bit cannot
  // leave every later word misaligned
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_shift_q <= '0;
      cfg_cnt_q <= '0;
    end else if (pre_lvl || trig_rise) begin
      cfg_cnt_q <= '0;
    end else if (filtered_shift_clock_rise) begin
      cfg_shift_q <= {cfg_shift_q[dosar_pkg::CFG_BITS-3:0], sdi_lvl}; // [R7]
      cfg_cnt_q <= (cfg_cnt_q == CFG_LAST) ? '0 : cfg_cnt_q + 1'b1;
    end
  end

  // Preset pin overrides; a full serial word takes effect at once
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_q <= dosar_pkg::CFG_RESET;
    end else if (pre_lvl) begin
      cfg_q <= sdi_lvl ? dosar_pkg::CFG_PRESET_HI
                       : dosar_pkg::CFG_PRESET_LO;   // [R3]
    end else if (filtered_shift_clock_rise && !trig_rise && cfg_cnt_q == CFG_LAST) begin
      cfg_q <= {cfg_shift_q, sdi_lvl};   // [R3] [R16]
    end
  end

  // Decimating filter
  logic [15:0] phase_q;
  logic signed [dosar_pkg::ACC_W-1:0] acc_q;
  logic signed [dosar_pkg::ACC_W-1:0] acc_sum;
  logic [15:0] phase_last;
  logic out_strobe;
  logic load_filt;
  logic [dosar_pkg::CODE_W-1:0] filt_word;

  // Limit follows the live ratio, so a new ratio takes hold mid-phase
  assign phase_last = 16'((32'h1 << cfg_q.dsr_log2) - 32'h1);
  assign acc_sum = acc_q + dosar_pkg::ACC_W'(signed'(core_result)); // [R15]
  assign out_strobe = conv_done && (phase_q == phase_last);
  // An align pulse in the same cycle drops the word and its ready edge
  assign load_filt = out_strobe && !align_rise;

  // Averaging trades latency for noise: one word per 2^n conversions
  always_comb begin
    if (cfg_q.filt == dosar_pkg::FILT_DECIMATE_ONLY) begin
      filt_word = core_result;
    end else begin
      filt_word = dosar_pkg::CODE_W'(acc_sum >>> cfg_q.dsr_log2); // [R14]
    end
  end

  // Alignment pulse clears the phase so that shared pulses line up
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phase_q <= '0;
      acc_q <= '0;
    end else if (align_rise) begin
      phase_q <= '0;   // [R5]
      acc_q <= '0;   // [R5]
    end else if (conv_done) begin
      if (out_strobe) begin
        phase_q <= '0;
        acc_q <= '0;
      end else begin
        phase_q <= phase_q + 16'h0001;
        acc_q <= acc_sum;   // [R14] [R15]
      end
    end
  end

  dosar_shift_out #(
    .WIDTH(dosar_pkg::CODE_W)
  ) u_filtered (
    .mclk(mclk),
    .resetn(resetn),
    .load(load_filt),
    .load_word(filt_word),
    .shift(filtered_shift_clock_rise),   // [R8]
    .sout(filtered_serial_out)
  );

  // Ready rises at each start so every new word gives a falling edge
  logic ready_n_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ready_n_q <= 1'b1;
    end else if (load_filt) begin
      ready_n_q <= 1'b0;   // [R6]
    end else if (conv_start) begin
      ready_n_q <= 1'b1;
    end
  end

  // Output enables and visible configuration
  logic fa_oe_n_q;
  logic db_oe_n_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fa_oe_n_q <= 1'b1;
      db_oe_n_q <= 1'b1;
    end else begin
      fa_oe_n_q <= ~lvl[dosar_pkg::LANE_RDA_N];   // [R1]
      db_oe_n_q <= ~lvl[dosar_pkg::LANE_RDB_N];   // [R2]
    end
  end

  // Every port is a bare register output, free of glitches at the pins
  assign busy = busy_q;
  assign filtered_ready_n = ready_n_q;
  assign filtered_serial_oe_n = fa_oe_n_q;
  assign direct_serial_oe_n = db_oe_n_q;
  assign gain_compensation_modes = cfg_q.gain_comp;
  assign filter_mode = cfg_q.filt;
  assign decimation_log2 = cfg_q.dsr_log2;

endmodule : dosar_top

/* File: verification/dosar_host_model.sv */
`timescale 1ns/10ps
module dosar_host_model (
  // Clock and wires
  input wire logic mclk,
  input wire logic filtered_pin,
  input wire logic direct_pin,
  // Pins driven by the host
  output logic conversion_trigger,
  output logic filter_phase_align,
  output logic preset_select,
  output logic config_serial_in,
  output logic filtered_shift_clock,
  output logic direct_shift_clock,
  output logic filtered_read_enable_n,
  output logic direct_read_enable_n
);
  // Half of a 160 ns shift clock period
  localparam int HALF = 8;

  // Idle levels; shift clocks stand low between words
  initial begin
    conversion_trigger = 1'b0;
    filter_phase_align = 1'b0;
    preset_select = 1'b0;
    config_serial_in = 1'b0;
    filtered_shift_clock = 1'b0;
    direct_shift_clock = 1'b0;
    filtered_read_enable_n = 1'b1;
    direct_read_enable_n = 1'b1;
  end

  // Trigger or align pulse; shift clocks stay quiet
  task automatic pulse(input logic align);
    @(posedge mclk);
    if (align) filter_phase_align <= 1'b1;
    else conversion_trigger <= 1'b1;
    repeat (HALF) @(posedge mclk);
    filter_phase_align <= 1'b0;
    conversion_trigger <= 1'b0;
  endtask : pulse

  // Preset pins, then time to settle
  task automatic preset(input logic on, input logic lvl);
    @(posedge mclk);
    preset_select <= on;
    config_serial_in <= lvl;
    repeat (10) @(posedge mclk);
  endtask : preset

  // Read 32 bits; cfg goes out MSB first, set up well before each rise
  task automatic xfer(input logic sel, input logic [7:0] cfg,
      output logic [31:0] w);
    @(posedge mclk);
    if (sel) filtered_read_enable_n <= 1'b0;
    else direct_read_enable_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      config_serial_in <= cfg[i % 8];
      repeat (HALF) @(posedge mclk);
      w[i] = sel ? filtered_pin : direct_pin;
      if (sel) filtered_shift_clock <= 1'b1;
      else direct_shift_clock <= 1'b1;
      repeat (HALF) @(posedge mclk);
      filtered_shift_clock <= 1'b0;
      direct_shift_clock <= 1'b0;
    end
    filtered_read_enable_n <= 1'b1;
    direct_read_enable_n <= 1'b1;
  endtask : xfer
endmodule : dosar_host_model

/* File: verification/dosar_top_sva.sv */
`timescale 1ns/10ps
module dosar_top_sva (
  // Clock, reset and host pins
  input wire logic mclk,
  input wire logic resetn,
  input wire logic conversion_trigger,
  input wire logic preset_select,
  input wire logic config_serial_in,
  input wire logic filtered_read_enable_n,
  input wire logic direct_read_enable_n,
  input wire logic core_overrange,
  // Device outputs
  input wire logic busy,
  input wire logic filtered_ready_n,
  input wire logic filtered_serial_oe_n,
  input wire logic direct_serial_out,
  input wire logic direct_serial_oe_n,
  input wire logic [3:0] decimation_log2
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  logic [7:0] busy_len_q;

  // Busy length; a late fall fails the check, but a busy stuck high never falls and is never checked
  always_ff @(posedge mclk) begin
    if (!resetn || !busy) begin
      busy_len_q <= 8'h00;
    end else begin
      busy_len_q <= busy_len_q + 8'h01;
    end
  end

  // One conversion period of mclk cycles, start edge included
  busy_len_a:
  assert property ($fell(busy) |-> busy_len_q == 8'(dosar_pkg::CONV_CYCLES))
    else $error("busy length wrong");
  busy_start_a:
  assert property ($rose(conversion_trigger) && !busy |-> ##[2:6] busy)
    else $error("trigger ignored");
  direct_msb_a:
  assert property ($fell(busy) |-> direct_serial_out == $past(core_overrange))
    else $error("direct word not loaded");
  ready_fall_a:
  assert property ($fell(filtered_ready_n) |-> $fell(busy))
    else $error("ready fell at wrong time");
  preset_hi_a:
  assert property ((preset_select && config_serial_in) [*6]
    |-> decimation_log2 == 4'h8) else $error("high preset wrong");
  preset_lo_a:
  assert property ((preset_select && !config_serial_in) [*6]
    |-> decimation_log2 == 4'h2) else $error("low preset wrong");
  filt_oe_a:
  assert property (($stable(filtered_read_enable_n)) [*6]
    |-> filtered_serial_oe_n == filtered_read_enable_n)
    else $error("filtered enable wrong");
  dir_oe_a:
  assert property (($stable(direct_read_enable_n)) [*6]
    |-> direct_serial_oe_n == direct_read_enable_n)
    else $error("direct enable wrong");
endmodule : dosar_top_sva

bind dosar_top dosar_top_sva chk (.*);

/* File: verification/dosar_top_tb.sv */
`timescale 1ns/10ps
module dosar_top_tb;
  typedef struct packed {
    logic [31:0] res;
    logic [6:0] cm;
    logic ovr;
  } dosar_row_type;

  // Signed extremes and both flag states
  localparam dosar_row_type ROWS [4] = '{
    '{32'h8000_0000, 7'h7f, 1'b1}, '{32'h7fff_ff00, 7'h00, 1'b0},
    '{32'hffff_fff0, 7'h55, 1'b1}, '{32'h1234_5678, 7'h2a, 1'b0}};

  logic mclk, resetn, core_overrange, busy, filtered_ready_n;
  logic [31:0] core_result, w, exp_c;
  logic [6:0] core_common_mode;
  logic filtered_serial_out, filtered_serial_oe_n;
  logic direct_serial_out, direct_serial_oe_n;
  logic [1:0] gain_compensation_modes, filter_mode;
  logic [3:0] decimation_log2;
  logic conversion_trigger, filter_phase_align, preset_select;
  logic config_serial_in, filtered_shift_clock, direct_shift_clock;
  logic filtered_read_enable_n, direct_read_enable_n;
  wire logic filtered_pin, direct_pin;
  wire logic [7:0] cfg_now;
  int bad_count, n_tests;
  longint s;

  // A released pin reads inverted, so a read before enable shows up
  assign filtered_pin = filtered_serial_oe_n ? ~filtered_serial_out
                                             : filtered_serial_out;
  assign direct_pin = direct_serial_oe_n ? ~direct_serial_out
                                         : direct_serial_out;
  assign cfg_now = {gain_compensation_modes, filter_mode, decimation_log2};

  dosar_top dut (.*);
  dosar_host_model host (.*);

  // System clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Idle state after any reset
  task automatic chk_idle();
    @(negedge mclk); // Outputs settle between edges
    chk("busy", 32'h0, busy);
    chk("ready_n", 32'h1, filtered_ready_n);
    chk("oe_n", 32'h3, {filtered_serial_oe_n, direct_serial_oe_n});
    chk("config", dosar_pkg::CFG_RESET, cfg_now);
  endtask : chk_idle

  // One conversion, core result held steady throughout
  task automatic convert(input dosar_row_type r);
    int n;
    n = 0;
    @(posedge mclk);
    core_result <= r.res;
    core_common_mode <= r.cm;
    core_overrange <= r.ovr;
    host.pulse(1'b0);
    chk("busy high", 32'h1, busy);
    while (busy === 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk("busy low", 32'h0, busy);
  endtask : convert

  // Hang guard, well beyond the expected few thousand cycles
  initial begin
    repeat (50000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    core_result = 32'h0;
    core_common_mode = 7'h0;
    core_overrange = 1'b0;
    bad_count = 0;
    n_tests = 0;
    s = 0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk_idle();
    // Each row read back on the direct port, then the average
    foreach (ROWS[i]) begin
      convert(ROWS[i]);
      host.xfer(1'b0, 8'h00, w);
      exp_c = {ROWS[i].ovr, ROWS[i].res[31:8], ROWS[i].cm};
      chk("composite", exp_c, w);
      s += longint'($signed(ROWS[i].res));
    end
    chk("ready_n", 32'h0, filtered_ready_n);
    host.xfer(1'b1, dosar_pkg::CFG_RESET, w);
    chk("average", 32'(s >>> 2), w);
    // Decimate only at ratio 1, back-to-back conversions
    host.xfer(1'b1, 8'hd0, w);
    chk("config", 32'hd0, cfg_now);
    convert('{32'h0bad_cafe, 7'h11, 1'b0});
    convert('{32'h8765_4321, 7'h22, 1'b1});
    chk("ready_n", 32'h0, filtered_ready_n);
    host.xfer(1'b0, 8'hd0, w);
    chk("latest", {1'b1, 24'h876543, 7'h22}, w);
    host.xfer(1'b1, 8'hd0, w);
    chk("decimated", 32'h8765_4321, w);
    // Ratio 2: align after one conversion restarts the pair
    host.xfer(1'b1, 8'h01, w);
    convert('{32'h4000_0000, 7'h00, 1'b0});
    host.pulse(1'b1);
    convert('{32'h0000_0100, 7'h00, 1'b0});
    chk("ready_n", 32'h1, filtered_ready_n);
    convert('{32'hffff_fe00, 7'h00, 1'b0});
    chk("ready_n", 32'h0, filtered_ready_n);
    host.xfer(1'b1, 8'h01, w);
    chk("aligned", 32'hffff_ff80, w);
    // Both presets
    host.preset(1'b1, 1'b1);
    chk("preset", 32'h8, decimation_log2);
    host.preset(1'b1, 1'b0);
    chk("preset", 32'h2, decimation_log2);
    host.preset(1'b0, 1'b0);
    // A serial word again, so the reset below has something to undo
    host.xfer(1'b1, 8'h5b, w);
    chk("config", 32'h5b, cfg_now);
    // Reset in mid-conversion
    host.pulse(1'b0);
    resetn <= 1'b0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk_idle();
    tally_and_finish();
  end
endmodule : dosar_top_tb
